//--- verilog/rws_consts.vh
// Constants for the reset and wake sequencer
`ifndef RWS_CONSTS_VH
`define RWS_CONSTS_VH
// Slow clock tick divider: 50 MHz / 32768 Hz, rounded down
`define RWS_SYS_HZ 50000000
`define RWS_SLOW_HZ 32768
`define RWS_SLOW_DIV (`RWS_SYS_HZ / `RWS_SLOW_HZ)
// Slow ticks per 1 Hz tick
`define RWS_SEC_DIV 32768
// Sequencing delays in slow periods, wake minimum in 1 Hz ticks
`define RWS_ASSERT_DLY 3'h2
`define RWS_PF_HOLD 3'h2
`define RWS_WAKE_MIN_SEC 2'h2
// PLL lock time in us and cycles at the system clock
`define RWS_PLL_LOCK_US 250
`define RWS_PLL_LOCK_CYC ((`RWS_PLL_LOCK_US * `RWS_SYS_HZ) / 1000000)
// Terminal counts, sized to their counters
`define RWS_SLOW_LAST 12'h5f4
`define RWS_SEC_LAST 15'h7fff
`define RWS_PLL_LAST 14'h30d3
`endif

//--- verilog/rws_sync.v
// Two-flop synchroniser
`timescale 1ns/1ps
module rws_sync (
  input wire clk_sys,
  input wire rst_n,
  input wire dIn,
  input wire rstVal,
  output reg dOut
);
  reg meta_r;
  // First flop feeds only the second
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= rstVal;
      dOut <= rstVal;
    end else begin
      meta_r <= dIn;
      dOut <= meta_r;
    end
  end
endmodule

//--- verilog/rws_sequencer.v
// Reset and wake sequencer of the clock and state controller
//
// Notes on behaviour
// RL1: Board holds power-on reset until crystal stable.
// RL2: Wake waits two 1 Hz ticks after power-on.
// RL3: Sample battery and power inputs in that window.
// RL4: Allow 250 us PLL lock before use.
// RL5: Power-on reset asserts output directly, no clock.
// RL6: Power-on release releases output directly.
// RL7: User reset asserts output after 2-4 periods.
// RL8: User release frees output within 0-2 periods.
// RL9: Wake stays low 2 periods after user release.
// RL10: User reset drops clock gate after 2-4 periods.
// RL11: Wake raises clock gate after 2-4 periods.
// RL12: Power fail asserts output 2-4, holds 2.
// RL13: Wake waits two 1 Hz ticks after power fail.
// RL14: Power fail drops clock gate after 2-4 periods.
// RL15: Synchronise user reset, power fail, wake inputs.
`timescale 1ns/1ps
`include "rws_consts.vh"
module rws_sequencer (
  input wire clk_sys,
  input wire rst_n,
  input wire power_on_reset_n,
  input wire user_reset_n,
  input wire power_fail_n,
  input wire wake_request,
  input wire battery_good,
  input wire external_power_n,
  output wire reset_output_n,
  output reg external_clock_gate,
  output reg batteryGoodLatched_r,
  output reg externalPowerLatched_r,
  output reg sampleWindow_r,
  output reg pllLocked_r,
  output reg wakeEarly_r
);
  localparam ST_OFF = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_DOWN = 2'h3;

  wire userResetSync;
  wire powerFailSync;
  wire wakeSync;
  reg [11:0] slowDiv_r;
  reg slowTick;
  reg [14:0] secDiv_r;
  reg secTick;
  reg [1:0] secCount_r;
  reg [1:0] state_r;
  reg [2:0] slowCount_r;
  reg [2:0] holdCount_r;
  reg [1:0] userRelCount_r;
  reg resetHold_r;
  reg userPrev_r;
  reg pfPrev_r;
  reg [13:0] pllCount_r;
  reg wakePrev_r;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  rws_sync uSyncUser (.clk_sys(clk_sys), .rst_n(rst_n), .dIn(user_reset_n), .rstVal(1'b1),
    .dOut(userResetSync)); // RL15
  rws_sync uSyncPf (.clk_sys(clk_sys), .rst_n(rst_n), .dIn(power_fail_n), .rstVal(1'b1),
    .dOut(powerFailSync)); // RL15
  rws_sync uSyncWake (.clk_sys(clk_sys), .rst_n(rst_n), .dIn(~wake_request), .rstVal(1'b1),
    .dOut(wakeSync)); // RL15

  ////////////////////////////////////////////////////////////////////////
  // Slow crystal tick and 1 Hz tick
  always @(posedge clk_sys) begin
    if (!rst_n || !power_on_reset_n) begin
      slowDiv_r <= 12'h000;
      slowTick <= 1'b0;
      secDiv_r <= 15'h0000;
      secTick <= 1'b0;
    end else begin
      slowTick <= 1'b0;
      secTick <= 1'b0;
      if (slowDiv_r == `RWS_SLOW_LAST) begin
        slowDiv_r <= 12'h000;
        slowTick <= 1'b1;
        if (secDiv_r == `RWS_SEC_LAST) begin
          secDiv_r <= 15'h0000;
          secTick <= 1'b1;
        end else begin
          secDiv_r <= secDiv_r + 15'h0001;
        end
      end else begin
        slowDiv_r <= slowDiv_r + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-on reset passes straight through, gated with sequenced hold
  assign reset_output_n = power_on_reset_n & ~resetHold_r; // RL5 RL6

  ////////////////////////////////////////////////////////////////////////
  // Main sequencing: reset hold, clock gate, wake qualification
  always @(posedge clk_sys) begin
    if (!rst_n || !power_on_reset_n) begin
      state_r <= ST_WAIT;
      secCount_r <= 2'h0;
      slowCount_r <= 3'h0;
      holdCount_r <= 3'h0;
      userRelCount_r <= 2'h0;
      resetHold_r <= 1'b0;
      userPrev_r <= 1'b1;
      pfPrev_r <= 1'b1;
      wakePrev_r <= 1'b0;
      external_clock_gate <= 1'b0;
      sampleWindow_r <= 1'b1;
      batteryGoodLatched_r <= 1'b0;
      externalPowerLatched_r <= 1'b1;
      wakeEarly_r <= 1'b0;
    end else begin
      userPrev_r <= userResetSync;
      pfPrev_r <= powerFailSync;
      wakePrev_r <= ~wakeSync;
      // Battery and supply sampled while qualification window is open
      if (sampleWindow_r) begin
        batteryGoodLatched_r <= battery_good; // RL3
        externalPowerLatched_r <= external_power_n; // RL3
      end
      // Count 1 Hz ticks after power-on or power-fail release
      if (secTick && secCount_r != `RWS_WAKE_MIN_SEC) begin
        secCount_r <= secCount_r + 2'h1; // RL2 RL13
      end
      if (secCount_r == `RWS_WAKE_MIN_SEC) begin
        sampleWindow_r <= 1'b0;
      end
      // Slow periods since user reset release
      if (!userResetSync) begin
        userRelCount_r <= 2'h0;
      end else if (slowTick && userRelCount_r != 2'h2) begin
        userRelCount_r <= userRelCount_r + 2'h1;
      end
      // User reset output follows, released as soon as the synchronised release is seen
      if (!userResetSync && slowTick && slowCount_r == `RWS_ASSERT_DLY) begin
        resetHold_r <= 1'b1; // RL7
        external_clock_gate <= 1'b0; // RL10
      end else if (userResetSync && !userPrev_r) begin
        resetHold_r <= 1'b0; // RL8
      end
      // Power-fail hold timer
      if (holdCount_r != 3'h0 && slowTick) begin
        holdCount_r <= holdCount_r - 3'h1;
        if (holdCount_r == 3'h1) begin
          resetHold_r <= 1'b0; // RL12
        end
      end
      if (!powerFailSync && slowTick && slowCount_r == `RWS_ASSERT_DLY && state_r != ST_DOWN) begin
        resetHold_r <= 1'b1; // RL12
        holdCount_r <= `RWS_PF_HOLD; // RL12
        external_clock_gate <= 1'b0; // RL14
        state_r <= ST_DOWN;
      end
      // Delay counter for assertion windows
      if (!userResetSync || (!powerFailSync && state_r != ST_DOWN) || (state_r == ST_WAIT && ~wakeSync)) begin
        if (slowTick && slowCount_r != 3'h7) begin
          slowCount_r <= slowCount_r + 3'h1;
        end
      end else begin
        slowCount_r <= 3'h0;
      end
      case (state_r)
        ST_OFF: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          // Wake before qualification is flagged, not acted on
          if (~wakeSync && (secCount_r != `RWS_WAKE_MIN_SEC || userRelCount_r != 2'h2)) begin
            wakeEarly_r <= 1'b1; // RL2 RL9 RL13
          end else if (~wakeSync && slowTick && slowCount_r == `RWS_ASSERT_DLY) begin
            external_clock_gate <= 1'b1; // RL11
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!userResetSync) begin
            state_r <= ST_WAIT;
          end
        end
        ST_DOWN: begin
          // Restart 1 Hz qualification after power-fail release
          if (powerFailSync) begin
            secCount_r <= 2'h0; // RL13
            state_r <= ST_WAIT;
          end
        end
        default: begin
          state_r <= ST_WAIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PLL lock timer after the clock gate opens
  always @(posedge clk_sys) begin
    if (!rst_n || !external_clock_gate) begin
      pllCount_r <= 14'h0000;
      pllLocked_r <= 1'b0;
    end else if (pllCount_r == `RWS_PLL_LAST) begin
      pllLocked_r <= 1'b1; // RL4
    end else begin
      pllCount_r <= pllCount_r + 14'h0001;
    end
  end
endmodule

//--- verification/rws_seq_props.sv
// Port assertions for the reset and wake sequencer
`timescale 1ns/1ps
module rws_seq_props (
  input logic clk_sys,
  input logic rst_n,
  input logic power_on_reset_n,
  input logic user_reset_n,
  input logic power_fail_n,
  input logic wake_request,
  input logic reset_output_n,
  input logic external_clock_gate,
  input logic sampleWindow_r,
  input logic wakeEarly_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [13:0] usrAge;
  logic [13:0] relAge;
  logic [13:0] pfAge;
  logic pfHit;
  // Cycle ages of trigger levels, saturating
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      usrAge <= 14'h0000;
      relAge <= 14'h0000;
      pfAge <= 14'h0000;
      pfHit <= 1'b0;
    end else begin
      usrAge <= user_reset_n ? 14'h0000 : (usrAge == 14'h3fff ? usrAge : usrAge + 14'h0001);
      relAge <= !user_reset_n ? 14'h0000 : (relAge == 14'h3fff ? relAge : relAge + 14'h0001);
      pfAge <= power_fail_n ? 14'h0000 : (pfAge == 14'h3fff ? pfAge : pfAge + 14'h0001);
      pfHit <= power_fail_n ? 1'b0 : (pfHit || !reset_output_n);
    end
  end
  ////////////////////////////////////////
  // Reset output against its triggers
  property p_porLow; !power_on_reset_n |-> !reset_output_n; endproperty
  a_porLow: assert property (p_porLow) else $error("output high in power-on");
  property p_porRel; $rose(power_on_reset_n) |-> reset_output_n; endproperty
  a_porRel: assert property (p_porRel) else $error("output late at power-on");
  property p_usrOn; !user_reset_n && power_on_reset_n && usrAge == 14'h189c |-> !reset_output_n; endproperty
  a_usrOn: assert property (p_usrOn) else $error("user reset missed");
  property p_usrOnMin; $fell(reset_output_n) && !user_reset_n && power_fail_n |-> usrAge >= 14'h0bb8; endproperty
  a_usrOnMin: assert property (p_usrOnMin) else $error("user reset too early");
  property p_usrOff; user_reset_n && power_fail_n && power_on_reset_n && relAge == 14'h0bf4 |-> reset_output_n;
  endproperty
  a_usrOff: assert property (p_usrOff) else $error("user release late");
  property p_pfOn; !power_fail_n && power_on_reset_n && pfAge == 14'h189c |-> pfHit; endproperty
  a_pfOn: assert property (p_pfOn) else $error("power fail missed");
  ////////////////////////////////////////
  // Clock gate and early wake
  property p_usrGate; !user_reset_n && usrAge == 14'h189c |-> !external_clock_gate; endproperty
  a_usrGate: assert property (p_usrGate) else $error("gate kept on user reset");
  property p_pfGate; !power_fail_n && pfAge == 14'h189c |-> !external_clock_gate; endproperty
  a_pfGate: assert property (p_pfGate) else $error("gate kept on power fail");
  property p_early; $rose(wake_request) && sampleWindow_r |-> ##[1:6] wakeEarly_r; endproperty
  a_early: assert property (p_early) else $error("early wake not flagged");
endmodule
bind rws_sequencer rws_seq_props props (.*);

//--- verification/rws_board.sv
// Board supervisor model driving reset, power and wake levels
`timescale 1ns/1ps
module rws_board #(parameter int STABLE = 30) (
  input logic clk_sys,
  output logic power_on_reset_n,
  output logic user_reset_n,
  output logic power_fail_n,
  output logic wake_request,
  output logic battery_good,
  output logic external_power_n
);
  // Power-on reset held until the slow crystal settles
  initial begin
    power_on_reset_n = 1'h0;
    external_power_n = 1'h0;
    {user_reset_n, power_fail_n, wake_request, battery_good} = 4'hd;
    repeat (STABLE) @(posedge clk_sys);
    power_on_reset_n <= 1'h1;
  end
  // Levels change just after a clock edge
  task automatic drive(input logic [3:0] v);
    @(posedge clk_sys);
    {user_reset_n, power_fail_n, wake_request, battery_good} <= v;
  endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the reset and wake sequencer
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic power_on_reset_n, user_reset_n, power_fail_n, wake_request, battery_good, external_power_n;
  logic reset_output_n, external_clock_gate, batteryGoodLatched_r, externalPowerLatched_r;
  logic sampleWindow_r, pllLocked_r, wakeEarly_r;
  int errors = 0;
  int checks_done = 0;
  int n;
  always #10 clk_sys = ~clk_sys;
  rws_sequencer dut (.*);
  rws_board board (.*);
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task waitOut(input logic lvl, input int lim);
    n = 0;
    while (reset_output_n !== lvl && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task end_sim;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_por;
    chk(reset_output_n, 1'h0);
    @(posedge power_on_reset_n);
    #1;
    chk(reset_output_n, 1'h1);
    chk({sampleWindow_r, wakeEarly_r, external_clock_gate, pllLocked_r}, 4'h8);
  endtask
  task t_user;
    board.drive(4'h5);
    waitOut(1'h0, 6400);
    chk(n >= 3000 && n <= 6300, 1'h1);
    chk(external_clock_gate, 1'h0);
    repeat (7000 - n) @(posedge clk_sys);
    board.drive(4'hd);
    waitOut(1'h1, 3200);
    chk(n <= 3060, 1'h1);
  endtask
  task t_pf;
    board.drive(4'h9);
    waitOut(1'h0, 6400);
    chk(n >= 3000 && n <= 6300, 1'h1);
    chk(external_clock_gate, 1'h0);
    waitOut(1'h1, 6400);
    chk(n >= 1500 && n <= 4600, 1'h1);
    repeat (200) @(posedge clk_sys);
    board.drive(4'hd);
  endtask
  task t_wake;
    board.drive(4'hf);
    repeat (6) @(posedge clk_sys);
    #1;
    chk(wakeEarly_r, 1'h1);
    repeat (6200) @(posedge clk_sys);
    #1;
    chk(external_clock_gate, 1'h0);
    chk({batteryGoodLatched_r, externalPowerLatched_r}, 2'h2);
    board.drive(4'hd);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_por;
    t_user;
    t_pf;
    t_wake;
    end_sim;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    end_sim;
  end
endmodule
